// File: hw/usb_fifo_status.sv
// FIFO status and sizing registers of a full-speed USB controller, with an AXI4-Lite slave.
`timescale 1ns/100ps

module usb_fifo_status (
	// Clock, reset and enable.
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	// AXI4-Lite write channels.
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// AXI4-Lite read channels.
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	// Receive status from the link side.
	input  wire logic        rxPushValid,
	output logic             rxPushReady,
	input  wire logic [3:0]  rxPushIndex,
	input  wire logic [10:0] rxPushBytes,
	input  wire logic [1:0]  rxPushPid,
	input  wire logic [3:0]  rxPushState,
	input  wire logic [3:0]  rxPushFrame,
	// Non-periodic transmit words toward the link side.
	output logic             txWordStrobe,
	output logic [31:0]      txWord,
	input  wire logic        txWordTaken,
	// Non-periodic request queue head toward the link side.
	output logic             reqHeadValid,
	output logic [7:0]       reqHead,
	input  wire logic        reqTaken
);

	function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
		input logic [31:0] newVal, input logic [3:0] strb);
		logic [31:0] res;
		res = oldVal;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = newVal[8*i +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic sameWord(input logic [7:0] a, input logic [7:0] b);
		return a[7:2] == b[7:2];
	endfunction

	function automatic logic legalState(input logic host, input logic [3:0] code);
		if (host) begin
			return code == usb_fifo_pkg::HS_IN_RECEIVED || code == usb_fifo_pkg::HS_IN_DONE
				|| code == usb_fifo_pkg::HS_TOGGLE_ERROR
				|| code == usb_fifo_pkg::HS_CHANNEL_HALTED;
		end
		return code == usb_fifo_pkg::DS_OUT_NAK || code == usb_fifo_pkg::DS_OUT_RECEIVED
			|| code == usb_fifo_pkg::DS_OUT_DONE || code == usb_fifo_pkg::DS_SETUP_DONE
			|| code == usb_fifo_pkg::DS_SETUP_RECEIVED;
	endfunction

	// Configuration, mode and transmit occupancy state.
	logic        hostMode_q;
	logic [15:0] rxDepthWords_q;
	logic [31:0] txLayout_q;
	logic [15:0] txUsed_q;

	// Request queue and receive status queue storage.
	logic [7:0]  reqMem [0:7];
	logic [2:0]  reqWr_q;
	logic [2:0]  reqRd_q;
	logic [3:0]  reqCount_q;
	logic [24:0] rxMem [0:3];
	logic [1:0]  rxWr_q;
	logic [1:0]  rxRd_q;
	logic [2:0]  rxCount_q;

	// Bus slave state.
	logic        awready_q;
	logic        wready_q;
	logic        awHeld_q;
	logic        wHeld_q;
	logic [7:0]  awAddr_q;
	logic [31:0] wData_q;
	logic [3:0]  wStrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	// Link-side output registers.
	logic        rxPushReady_q;
	logic        txWordStrobe_q;
	logic [31:0] txWord_q;
	logic        reqHeadValid_q;
	logic [7:0]  reqHead_q;

	// Write channel handshake and decode.
	wire         awTake = ce && awvalid && awready_q;
	wire         wTake = ce && wvalid && wready_q;
	wire         awHave = awHeld_q || awTake;
	wire         wHave = wHeld_q || wTake;
	wire         doWrite = awHave && wHave && !bvalid_q;
	wire [7:0]   wrAddr = awHeld_q ? awAddr_q : awaddr;
	wire [31:0]  wrData = wHeld_q ? wData_q : wdata;
	wire [3:0]   wrStrb = wHeld_q ? wStrb_q : wstrb;
	wire         awHeld_d = awHave && !doWrite;
	wire         wHeld_d = wHave && !doWrite;
	wire         bvalid_d = doWrite || (bvalid_q && !bready);
	wire         wrDepth = doWrite && sameWord(wrAddr, usb_fifo_pkg::RX_DEPTH_OFFSET);
	wire         wrLayout = doWrite && sameWord(wrAddr, usb_fifo_pkg::TX_LAYOUT_OFFSET);
	wire         wrMode = doWrite && sameWord(wrAddr, usb_fifo_pkg::MODE_CTRL_OFFSET);
	wire         wrTxPush = doWrite && sameWord(wrAddr, usb_fifo_pkg::TX_PUSH_OFFSET);
	wire         wrReqPush = doWrite && sameWord(wrAddr, usb_fifo_pkg::REQ_PUSH_OFFSET);
	wire         wrReadOnly = sameWord(wrAddr, usb_fifo_pkg::RX_PEEK_OFFSET)
		|| sameWord(wrAddr, usb_fifo_pkg::RX_POP_OFFSET)
		|| sameWord(wrAddr, usb_fifo_pkg::NP_STATE_OFFSET);
	wire         wrMapped = wrReadOnly || sameWord(wrAddr, usb_fifo_pkg::RX_DEPTH_OFFSET)
		|| sameWord(wrAddr, usb_fifo_pkg::TX_LAYOUT_OFFSET)
		|| sameWord(wrAddr, usb_fifo_pkg::MODE_CTRL_OFFSET)
		|| sameWord(wrAddr, usb_fifo_pkg::TX_PUSH_OFFSET)
		|| sameWord(wrAddr, usb_fifo_pkg::REQ_PUSH_OFFSET);
	wire [31:0]  depthMerged = mergeBytes({16'h0000, rxDepthWords_q}, wrData, wrStrb);

	// Transmit word accounting; the depth field is used as written, unclamped. A zero depth
	// lies outside the legal range and means the FIFO was never sized, so the free count
	// then shows the reset free space instead of a full FIFO.
	wire [15:0]  depthField = txLayout_q[31:usb_fifo_pkg::DEPTH_LSB];
	wire [15:0]  txDepth = (depthField != 16'h0000) ? depthField
		: usb_fifo_pkg::NP_STATE_RESET[15:0];
	wire [15:0]  freeWords = (txUsed_q >= txDepth) ? 16'h0000 : txDepth - txUsed_q;
	wire         txAccept = wrTxPush && freeWords != 16'h0000;
	wire         txPop = ce && txWordTaken && txUsed_q != 16'h0000;

	// Request queue accounting.
	wire         reqAccept = wrReqPush && wrStrb[0] && reqCount_q != usb_fifo_pkg::REQ_SLOTS
		&& (hostMode_q || !wrData[usb_fifo_pkg::REQ_DIR_BIT]);
	wire         reqPop = ce && reqTaken && reqHeadValid_q;
	wire [7:0]   freeSlots = {4'h0, usb_fifo_pkg::REQ_SLOTS - reqCount_q};
	wire [6:0]   queueTop = (reqCount_q != 4'h0) ? reqMem[reqRd_q][6:0] : 7'h00;

	// Receive status queue accounting.
	wire         arTake = ce && arvalid && arready_q;
	wire         rxAccept = ce && rxPushValid && rxPushReady_q
		&& legalState(hostMode_q, rxPushState);
	wire         rxPop = arTake && sameWord(araddr, usb_fifo_pkg::RX_POP_OFFSET)
		&& rxCount_q != 3'h0;
	wire [2:0]   rxCount_d = rxCount_q + {2'b00, rxAccept} - {2'b00, rxPop};
	wire [3:0]   frameBits = hostMode_q ? 4'h0 : rxPushFrame;
	wire [24:0]  rxEntry = {frameBits, rxPushState, rxPushPid, rxPushBytes, rxPushIndex};
	wire [31:0]  rxHead = (rxCount_q != 3'h0) ? {7'h00, rxMem[rxRd_q]} : 32'h00000000;

	// Read data selection; reserved bits are zero by construction.
	wire [31:0]  npState = {1'b0, queueTop, freeSlots, freeWords};
	wire         rdRx = sameWord(araddr, usb_fifo_pkg::RX_PEEK_OFFSET)
		|| sameWord(araddr, usb_fifo_pkg::RX_POP_OFFSET);
	wire         rdDepth = sameWord(araddr, usb_fifo_pkg::RX_DEPTH_OFFSET);
	wire         rdLayout = sameWord(araddr, usb_fifo_pkg::TX_LAYOUT_OFFSET);
	wire         rdState = sameWord(araddr, usb_fifo_pkg::NP_STATE_OFFSET);
	wire         rdMode = sameWord(araddr, usb_fifo_pkg::MODE_CTRL_OFFSET);
	wire         rdPushOnly = sameWord(araddr, usb_fifo_pkg::TX_PUSH_OFFSET)
		|| sameWord(araddr, usb_fifo_pkg::REQ_PUSH_OFFSET);
	wire [31:0]  rdValue = rdRx ? rxHead
		: rdDepth ? {16'h0000, rxDepthWords_q}
		: rdLayout ? txLayout_q
		: rdState ? npState
		: rdMode ? {31'h00000000, hostMode_q}
		: 32'h00000000;
	wire         rdMapped = rdRx || rdDepth || rdLayout || rdState || rdMode || rdPushOnly;

	// Write channel.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= usb_fifo_pkg::RESP_OKAY;
		end else if (ce) begin
			awHeld_q <= awHeld_d;
			wHeld_q <= wHeld_d;
			awready_q <= !awHeld_d && !bvalid_d;
			wready_q <= !wHeld_d && !bvalid_d;
			bvalid_q <= bvalid_d;
			if (awTake) begin
				awAddr_q <= awaddr;
			end
			if (wTake) begin
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (doWrite) begin
				bresp_q <= wrMapped ? usb_fifo_pkg::RESP_OKAY : usb_fifo_pkg::RESP_SLVERR;
			end
		end
	end

	// Read channel; a pop read removes the entry in the same edge that takes the address.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= usb_fifo_pkg::RESP_OKAY;
		end else if (ce) begin
			if (arTake) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rdValue;
				rresp_q <= rdMapped ? usb_fifo_pkg::RESP_OKAY : usb_fifo_pkg::RESP_SLVERR;
			end else if (rvalid_q && rready) begin
				arready_q <= 1'b1;
				rvalid_q <= 1'b0;
			end
		end
	end

	// Software-written configuration.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hostMode_q <= usb_fifo_pkg::HOST_MODE_RESET;
			rxDepthWords_q <= usb_fifo_pkg::RX_DEPTH_RESET[15:0];
			txLayout_q <= usb_fifo_pkg::TX_LAYOUT_RESET;
		end else if (ce) begin
			if (wrMode && wrStrb[0]) begin
				hostMode_q <= wrData[0];
			end
			if (wrDepth) begin
				rxDepthWords_q <= depthMerged[15:0];
			end
			if (wrLayout) begin
				txLayout_q <= mergeBytes(txLayout_q, wrData, wrStrb);
			end
		end
	end

	// Transmit word occupancy and the word handed to the link.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txUsed_q <= 16'h0000;
			txWordStrobe_q <= 1'b0;
			txWord_q <= 32'h00000000;
		end else if (ce) begin
			txUsed_q <= txUsed_q + {15'h0000, txAccept} - {15'h0000, txPop};
			txWordStrobe_q <= txAccept;
			if (txAccept) begin
				txWord_q <= wrData;
			end
		end
	end

	// Request queue. The head output lags the queue by one edge, so a taken head
	// drops valid for one cycle before the next entry shows; this keeps outputs flopped.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reqWr_q <= 3'h0;
			reqRd_q <= 3'h0;
			reqCount_q <= 4'h0;
			reqHeadValid_q <= 1'b0;
			reqHead_q <= 8'h00;
		end else if (ce) begin
			if (reqAccept) begin
				reqMem[reqWr_q] <= wrData[7:0];
				reqWr_q <= reqWr_q + 3'h1;
			end
			if (reqPop) begin
				reqRd_q <= reqRd_q + 3'h1;
			end
			reqCount_q <= reqCount_q + {3'h0, reqAccept} - {3'h0, reqPop};
			reqHeadValid_q <= reqCount_q != 4'h0 && !reqPop;
			reqHead_q <= reqMem[reqRd_q];
		end
	end

	// Receive status queue.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rxWr_q <= 2'h0;
			rxRd_q <= 2'h0;
			rxCount_q <= 3'h0;
			rxPushReady_q <= 1'b1;
		end else if (ce) begin
			if (rxAccept) begin
				rxMem[rxWr_q] <= rxEntry;
				rxWr_q <= rxWr_q + 2'h1;
			end
			if (rxPop) begin
				rxRd_q <= rxRd_q + 2'h1;
			end
			rxCount_q <= rxCount_d;
			rxPushReady_q <= rxCount_d != usb_fifo_pkg::RX_SLOTS;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign rxPushReady = rxPushReady_q;
	assign txWordStrobe = txWordStrobe_q;
	assign txWord = txWord_q;
	assign reqHeadValid = reqHeadValid_q;
	assign reqHead = reqHead_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_peek_keeps_entry: assert property (
		(arTake && sameWord(araddr, usb_fifo_pkg::RX_PEEK_OFFSET) && !rxAccept)
		|=> rxCount_q == $past(rxCount_q))
		else $error("peek read changed the receive queue");

	a_pop_removes_entry: assert property (
		(rxPop && !rxAccept) |=> rxCount_q == $past(rxCount_q) - 3'h1)
		else $error("pop read did not remove one entry");

	a_host_frame_zero: assert property (
		(rxAccept && hostMode_q) |=> rxMem[$past(rxWr_q)][24:21] == 4'h0)
		else $error("host mode stored frame bits");

	a_host_state_legal: assert property (
		(rxAccept && hostMode_q) |-> rxPushState inside {4'h2, 4'h3, 4'h5, 4'h7})
		else $error("illegal host packet status accepted");

	a_device_state_legal: assert property (
		(rxAccept && !hostMode_q) |-> rxPushState inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6})
		else $error("illegal device packet status accepted");

	a_free_words_sum: assert property (
		(txUsed_q <= txDepth) |-> npState[15:0] + txUsed_q == txDepth)
		else $error("free words disagree with occupancy");

	a_free_slots_sum: assert property (
		npState[23:16] + {4'h0, reqCount_q} == 8'h08)
		else $error("free slots disagree with queue count");

	a_device_no_out: assert property (
		(wrReqPush && wrData[usb_fifo_pkg::REQ_DIR_BIT] && !hostMode_q)
		|=> reqCount_q <= $past(reqCount_q))
		else $error("device mode accepted an OUT request");

	a_empty_top_zero: assert property (
		(reqCount_q == 4'h0) |-> npState[30:24] == 7'h00)
		else $error("empty queue shows a top entry");

	a_tx_push_counts: assert property (
		(txAccept && !txPop) |=> (txUsed_q == $past(txUsed_q) + 16'h0001) && txWordStrobe_q)
		else $error("transmit push not counted");

	c_rx_pop: cover property (rxPop ##[1:4] (rvalid_q && rready));
	c_tx_full: cover property (txUsed_q != 16'h0000 && freeWords == 16'h0000);
	c_req_full: cover property (reqCount_q == usb_fifo_pkg::REQ_SLOTS ##1 reqPop);

endmodule

// File: pkg/usb_fifo_pkg.sv
// Register map, field layout and code constants for the USB FIFO status and sizing block.
package usb_fifo_pkg;

	// Register byte offsets.
	localparam logic [7:0] RX_PEEK_OFFSET   = 8'h1C;
	localparam logic [7:0] RX_POP_OFFSET    = 8'h20;
	localparam logic [7:0] RX_DEPTH_OFFSET  = 8'h24;
	localparam logic [7:0] TX_LAYOUT_OFFSET = 8'h28;
	localparam logic [7:0] NP_STATE_OFFSET  = 8'h2C;
	localparam logic [7:0] MODE_CTRL_OFFSET = 8'h30;
	localparam logic [7:0] TX_PUSH_OFFSET   = 8'h34;
	localparam logic [7:0] REQ_PUSH_OFFSET  = 8'h38;

	// Reset values.
	localparam logic [31:0] RX_DEPTH_RESET  = 32'h00000200;
	localparam logic [31:0] TX_LAYOUT_RESET = 32'h00000200;
	localparam logic [31:0] NP_STATE_RESET  = 32'h00080200;
	localparam logic        HOST_MODE_RESET = 1'b0;

	// Receive-status word field positions.
	localparam int INDEX_LSB = 0;
	localparam int BYTES_LSB = 4;
	localparam int PID_LSB   = 15;
	localparam int STATE_LSB = 17;
	localparam int FRAME_LSB = 21;

	// Queue-state and layout field positions.
	localparam int FREE_SLOTS_LSB = 16;
	localparam int QUEUE_TOP_LSB  = 24;
	localparam int DEPTH_LSB      = 16;
	localparam int REQ_DIR_BIT    = 7;

	// Queue sizes.
	localparam logic [3:0] REQ_SLOTS = 4'h8;
	localparam logic [2:0] RX_SLOTS  = 3'h4;

	// Data PID codes.
	localparam logic [1:0] PID_DATA0 = 2'h0;
	localparam logic [1:0] PID_DATA1 = 2'h2;
	localparam logic [1:0] PID_DATA2 = 2'h1;
	localparam logic [1:0] PID_MDATA = 2'h3;

	// Packet status codes, host mode.
	localparam logic [3:0] HS_IN_RECEIVED    = 4'h2;
	localparam logic [3:0] HS_IN_DONE        = 4'h3;
	localparam logic [3:0] HS_TOGGLE_ERROR   = 4'h5;
	localparam logic [3:0] HS_CHANNEL_HALTED = 4'h7;

	// Packet status codes, device mode.
	localparam logic [3:0] DS_OUT_NAK        = 4'h1;
	localparam logic [3:0] DS_OUT_RECEIVED   = 4'h2;
	localparam logic [3:0] DS_OUT_DONE       = 4'h3;
	localparam logic [3:0] DS_SETUP_DONE     = 4'h4;
	localparam logic [3:0] DS_SETUP_RECEIVED = 4'h6;

	// Request queue entry types.
	localparam logic [1:0] ENTRY_TOKEN = 2'h0;
	localparam logic [1:0] ENTRY_ZLP   = 2'h1;
	localparam logic [1:0] ENTRY_PING  = 2'h2;
	localparam logic [1:0] ENTRY_HALT  = 2'h3;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: testbench/link_model.sv
// Link-side partner model: offers receive-status entries and drains transmit words and requests.
`timescale 1ns/100ps

module link_model (
	// Clock, reset and enable.
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic        drainEn,
	// Receive status offered to the block.
	output logic             rxPushValid,
	input  wire logic        rxPushReady,
	output logic [3:0]       rxPushIndex,
	output logic [10:0]      rxPushBytes,
	output logic [1:0]       rxPushPid,
	output logic [3:0]       rxPushState,
	output logic [3:0]       rxPushFrame,
	// Transmit words and requests from the block.
	input  wire logic        txWordStrobe,
	output logic             txWordTaken,
	input  wire logic        reqHeadValid,
	output logic             reqTaken
);
	int   pendWords;
	logic wordGone;
	logic headGone;

	assign wordGone = txWordTaken && ce;
	assign headGone = reqTaken && ce;

	initial {rxPushValid, rxPushFrame, rxPushState, rxPushPid, rxPushBytes, rxPushIndex} = '0;

	// Between entries the payload shows its inverse, so a stale field cannot pass for a fresh one.
	task automatic push(input logic [24:0] e);
		@(posedge clk);
		rxPushValid <= 1'b1;
		{rxPushFrame, rxPushState, rxPushPid, rxPushBytes, rxPushIndex} <= e;
		do @(posedge clk); while (!(rxPushReady && ce));
		rxPushValid <= 1'b0;
		{rxPushFrame, rxPushState, rxPushPid, rxPushBytes, rxPushIndex} <= ~e;
	endtask

	// A take is held until an enabled edge, because a frozen block ignores it.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pendWords <= 0;
			txWordTaken <= 1'b0;
			reqTaken <= 1'b0;
		end else begin
			pendWords <= pendWords + int'(txWordStrobe && ce) - int'(wordGone);
			txWordTaken <= drainEn && (pendWords > int'(wordGone));
			reqTaken <= drainEn && reqHeadValid && !headGone;
		end
	end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the USB FIFO status and sizing block.
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
	$display("wrong value at %0t: got %0h want %0h", $time, got, exp); end end

module tb_top;
	logic        clk, reset_n, ce, drainEn;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, rxPushValid, rxPushReady;
	logic        txWordStrobe, txWordTaken, reqHeadValid, reqTaken;
	logic [7:0]  awaddr, araddr, reqHead, hExp;
	logic [31:0] wdata, rdata, txWord, v, w, tExp;
	logic [3:0]  wstrb, rxPushIndex, rxPushState, rxPushFrame, st;
	logic [1:0]  bresp, rresp, rxPushPid, bExp;
	logic [10:0] rxPushBytes;
	logic [24:0] e;
	logic [33:0] rExp;
	logic [31:0] seed = 32'h00010E9F;
	int          failures, num_checks, ticks, free;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	logic [31:0] tq[$];
	logic [7:0]  hq[$];
	logic [3:0]  codes[2][5] = '{'{4'h1, 4'h2, 4'h3, 4'h4, 4'h6}, '{4'h2, 4'h3, 4'h5, 4'h7, 4'h0}};

	usb_fifo_status dut (.clk, .reset_n, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
		.rdata, .rresp, .rxPushValid, .rxPushReady, .rxPushIndex, .rxPushBytes, .rxPushPid,
		.rxPushState, .rxPushFrame, .txWordStrobe, .txWord, .txWordTaken, .reqHeadValid,
		.reqHead, .reqTaken);
	link_model lm (.clk, .reset_n, .ce, .drainEn, .rxPushValid, .rxPushReady, .rxPushIndex,
		.rxPushBytes, .rxPushPid, .rxPushState, .rxPushFrame, .txWordStrobe, .txWordTaken,
		.reqHeadValid, .reqTaken);

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task end_of_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = usb_fifo_pkg::RESP_OKAY, input logic [3:0] s = 4'hF);
		bit ta, tw, tb;
		bq.push_back(r);
		@(posedge clk);
		awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
		while (!tb) begin
			@(posedge clk);
			if (ce && awready && !ta) begin ta = 1; awvalid <= 1'b0; end
			if (ce && wready && !tw) begin tw = 1; wvalid <= 1'b0; end
			if (ce && bvalid) begin tb = 1; bready <= 1'b0; end
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = usb_fifo_pkg::RESP_OKAY);
		bit ta, tr;
		rq.push_back({r, d});
		@(posedge clk);
		arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
		while (!tr) begin
			@(posedge clk);
			if (ce && arready && !ta) begin ta = 1; arvalid <= 1'b0; end
			if (ce && rvalid) begin tr = 1; rready <= 1'b0; end
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// The enable drops at random on about one edge in eight, so that handshakes also meet frozen cycles.
	always @(posedge clk) begin
		ticks++;
		ce <= (rnd() % 8) != 0;
		if (ticks == 20000) begin failures++; end_of_test(); end
	end

	always @(posedge clk) begin
		if (reset_n && ce && rvalid && rready) begin
			rExp = rq.pop_front();
			`CHK({rresp, rdata}, rExp)
		end
		if (reset_n && ce && bvalid && bready) begin
			bExp = bq.pop_front();
			`CHK(bresp, bExp)
		end
		if (reset_n && ce && txWordStrobe) begin
			tExp = tq.pop_front();
			`CHK(txWord, tExp)
		end
		if (reset_n && ce && reqTaken && reqHeadValid) begin
			hExp = hq.pop_front();
			`CHK(reqHead, hExp)
		end
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, drainEn} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
		ce = 1'b1;
		reset_n = 1'b0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		rd(usb_fifo_pkg::RX_DEPTH_OFFSET, 32'h00000200);
		rd(usb_fifo_pkg::TX_LAYOUT_OFFSET, 32'h00000200);
		rd(usb_fifo_pkg::NP_STATE_OFFSET, 32'h00080200);
		rd(usb_fifo_pkg::RX_PEEK_OFFSET, 32'h00000000);
		rd(8'h3C, 32'h00000000, usb_fifo_pkg::RESP_SLVERR);
		wr(8'h3C, 32'hFFFFFFFF, usb_fifo_pkg::RESP_SLVERR);
		v = rnd();
		v[15:0] = 16'(16 + v[15:0] % 241);
		wr(usb_fifo_pkg::RX_DEPTH_OFFSET, v);
		rd(usb_fifo_pkg::RX_DEPTH_OFFSET, {16'h0000, v[15:0]});
		for (int m = 0; m < 2; m++) begin
			wr(usb_fifo_pkg::MODE_CTRL_OFFSET, 32'(m));
			v = rnd();
			v[31:16] = 16'(16 + v[31:16] % 241);
			wr(usb_fifo_pkg::TX_LAYOUT_OFFSET, v);
			rd(usb_fifo_pkg::TX_LAYOUT_OFFSET, v);
			w = rnd();
			wr(usb_fifo_pkg::TX_LAYOUT_OFFSET, w, usb_fifo_pkg::RESP_OKAY, 4'h3);
			rd(usb_fifo_pkg::TX_LAYOUT_OFFSET, {v[31:16], w[15:0]});
			for (int i = 0; i < 5 - m; i++) begin
				v = rnd();
				e = {v[24:21], codes[m][i], 2'(i), v[14:4], v[3:0]};
				lm.push(e);
				v = {7'h00, e};
				if (m == 1) v[24:21] = 4'h0;
				rd(usb_fifo_pkg::RX_PEEK_OFFSET, v);
				rd(usb_fifo_pkg::RX_POP_OFFSET, v);
				rd(usb_fifo_pkg::RX_PEEK_OFFSET, 32'h00000000);
			end
		end
		st = usb_fifo_pkg::HS_IN_DONE;
		for (int i = 0; i < 4; i++) lm.push({4'h0, st, 2'h0, 11'(i * 99), 4'(i)});
		repeat (2) @(posedge clk);
		`CHK(rxPushReady, 1'b0)
		for (int i = 0; i < 4; i++)
			rd(usb_fifo_pkg::RX_POP_OFFSET, {11'h000, st, 2'h0, 11'(i * 99), 4'(i)});
		lm.push({4'h0, usb_fifo_pkg::DS_SETUP_DONE, 2'h0, 11'h005, 4'h1});
		rd(usb_fifo_pkg::RX_PEEK_OFFSET, 32'h00000000);
		v = rnd();
		wr(usb_fifo_pkg::TX_LAYOUT_OFFSET, {16'h0010, v[15:0]});
		for (int k = 0; k < 17; k++) begin
			v = rnd();
			if (k < 16) tq.push_back(v);
			wr(usb_fifo_pkg::TX_PUSH_OFFSET, v);
			free = (k < 15) ? 15 - k : 0;
			rd(usb_fifo_pkg::NP_STATE_OFFSET, {16'h0008, 16'(free)});
		end
		drainEn <= 1'b1;
		while (lm.pendWords != 0) @(posedge clk);
		repeat (2) @(posedge clk);
		drainEn <= 1'b0;
		rd(usb_fifo_pkg::NP_STATE_OFFSET, 32'h00080010);
		wr(usb_fifo_pkg::MODE_CTRL_OFFSET, 32'h00000000);
		wr(usb_fifo_pkg::REQ_PUSH_OFFSET, 32'h00000080);
		rd(usb_fifo_pkg::NP_STATE_OFFSET, 32'h00080010);
		for (int i = 0; i < 9; i++) begin
			wr(usb_fifo_pkg::REQ_PUSH_OFFSET, {24'h0, 1'b0, 4'(15 - i), 2'(i), 1'(i)});
			if (i < 8) hq.push_back({1'b0, 4'(15 - i), 2'(i), 1'(i)});
			free = (i < 8) ? 7 - i : 0;
			rd(usb_fifo_pkg::NP_STATE_OFFSET, {8'h78, 8'(free), 16'h0010});
		end
		wr(usb_fifo_pkg::MODE_CTRL_OFFSET, 32'h00000001);
		hq.push_back(8'hFF);
		drainEn <= 1'b1;
		while (hq.size() > 1) @(posedge clk);
		wr(usb_fifo_pkg::REQ_PUSH_OFFSET, 32'h000000FF);
		while (hq.size() != 0) @(posedge clk);
		repeat (2) @(posedge clk);
		drainEn <= 1'b0;
		rd(usb_fifo_pkg::NP_STATE_OFFSET, 32'h00080010);
		end_of_test();
	end
endmodule
